//--- core/pupc_pkg.sv
// Constants and types shared by the profile, update and power-down control block
package pupc_pkg;

	localparam int PUPC_NPROF = 8;
	localparam int PUPC_PROFW = 3;
	localparam int PUPC_ADDRW = 10;
	localparam int PUPC_STEPW = 16;
	localparam int PUPC_RATEW = 32;
	localparam int PUPC_MODEW = 3;
	localparam int PUPC_PDW = 4;

	// Power-down bit positions
	localparam int PUPC_PD_DIGITAL = 0;
	localparam int PUPC_PD_DAC = 1;
	localparam int PUPC_PD_AUX = 2;
	localparam int PUPC_PD_REFCLK = 3;

	// RAM operating mode code for continuous recirculate
	localparam logic [2:0] PUPC_MODE_RECIRC = 3'h4;

	// Reset values, and the largest rate word that holds the strobe static
	localparam logic [1:0] PUPC_RATE_CTRL_RST = 2'h0;
	localparam logic [31:0] PUPC_RATE_WORD_RST = 32'h0000FFFF;
	localparam logic [31:0] PUPC_RATE_STATIC_MAX = 32'h00000003;

	// Timing, all in core clock cycles
	localparam logic [6:0] PUPC_PULSE_BASE = 7'h0C;
	localparam logic [4:0] PUPC_PRESCALE_BASE = 5'h04;
	localparam logic [1:0] PUPC_SWEEP_CYCLES = 2'h2;
	localparam logic [1:0] PUPC_SYNC_FIRE_PHASE = 2'h1;

	typedef enum logic [1:0] {
		PUPC_SEQ_IDLE = 2'b00,
		PUPC_SEQ_RUN = 2'b01,
		PUPC_SEQ_END = 2'b11
	} pupc_seq_t;

endpackage

//--- core/pupc_sync.sv
// Two-flop synchroniser for pin levels entering the core clock domain
`timescale 1ns/10ps
module pupc_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// Data
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	logic [W-1:0] meta;

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			meta <= '0;
			dout <= '0;
		end
		else
		begin
			meta <= din;
			dout <= meta;
		end
	end
endmodule // pupc_sync

//--- core/pupc_ctrl.sv
// Profile select, parameter update, recirculate sequencer and power-down control
`timescale 1ns/10ps
module pupc_ctrl (
	// Clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// Profile and update pins
	input wire logic [pupc_pkg::PUPC_PROFW-1:0] profilePin,
	input wire logic updateStrobeIn,
	output logic updateStrobeOut,
	output logic updateStrobeOe,
	output logic syncClk,
	// Buffered control write from the serial port
	input wire logic ctlWrEn,
	input wire logic ctlWrRamEnable,
	input wire logic [pupc_pkg::PUPC_MODEW-1:0] ctlWrRamMode,
	input wire logic ctlWrNoDwellHigh,
	input wire logic ctlWrIntUpdate,
	input wire logic [1:0] ctlWrRateCtrl,
	input wire logic [pupc_pkg::PUPC_RATEW-1:0] ctlWrRateWord,
	input wire logic [pupc_pkg::PUPC_PDW-1:0] ctlWrPowerDown,
	input wire logic ctlWrExtPdFast,
	// Buffered profile write from the serial port
	input wire logic profWrEn,
	input wire logic [pupc_pkg::PUPC_PROFW-1:0] profWrIndex,
	input wire logic [pupc_pkg::PUPC_ADDRW-1:0] profWrStart,
	input wire logic [pupc_pkg::PUPC_ADDRW-1:0] profWrEnd,
	input wire logic [pupc_pkg::PUPC_STEPW-1:0] profWrStep,
	// Power-down pin
	input wire logic external_powerdown_pin,
	// Active state
	output logic [pupc_pkg::PUPC_PROFW-1:0] activeProfile,
	output logic singleToneFormat,
	output logic noDwellHighEff,
	output logic [pupc_pkg::PUPC_ADDRW-1:0] ramAddr,
	output logic sweep_over_flag,
	output logic transferPulse,
	// Power-down outputs
	output logic pdDigital,
	output logic pdDac,
	output logic pdAux,
	output logic pdRefclk,
	output logic keepBiasPll
);
	import pupc_pkg::*;

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	logic [PUPC_PROFW-1:0] profSync;
	logic [PUPC_PROFW-1:0] profPrev;
	logic strobeSync;
	logic strobePrev;
	logic [1:0] divCnt;
	logic xferPending;
	logic xferNow;
	logic profChange;
	logic extRise;
	logic intUpdate;
	logic coreDown;
	logic wrAllowed;

	logic bufRamEnable;
	logic [PUPC_MODEW-1:0] bufRamMode;
	logic bufNoDwell;
	logic bufIntUpdate;
	logic [1:0] bufRateCtrl;
	logic [PUPC_RATEW-1:0] bufRateWord;
	logic actRamEnable;
	logic [PUPC_MODEW-1:0] actRamMode;
	logic actNoDwell;
	logic actIntUpdate;
	logic [1:0] actRateCtrl;
	logic [PUPC_RATEW-1:0] actRateWord;
	logic [PUPC_PDW-1:0] pdBits;
	logic extPdFast;

	logic [PUPC_ADDRW-1:0] actStart [PUPC_NPROF];
	logic [PUPC_ADDRW-1:0] actEnd [PUPC_NPROF];
	logic [PUPC_STEPW-1:0] actStep [PUPC_NPROF];

	logic [4:0] preCnt;
	logic [PUPC_RATEW-1:0] rateCnt;
	logic [6:0] pulseCnt;
	logic rateStatic;

	pupc_seq_t seqState;
	logic [PUPC_STEPW-1:0] stepCnt;
	logic [1:0] sweepCnt;
	logic recirc;
	logic stepExpire;
	logic [PUPC_ADDRW-1:0] selStart;
	logic [PUPC_ADDRW-1:0] selEnd;
	logic [PUPC_STEPW-1:0] selStep;

	// ------------------------------------------------------------
	// Pin synchronisers and edge detect
	// ------------------------------------------------------------
	pupc_sync #(.W(PUPC_PROFW + 1)) u_pinSync (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.din({profilePin, updateStrobeIn}),
		.dout({profSync, strobeSync})
	);

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			profPrev <= '0;
			strobePrev <= 1'b0;
		end
		else
		begin
			profPrev <= profSync;
			strobePrev <= strobeSync;
		end
	end

	// The pin is ours while the internal timer drives it, so its echo is not an update
	assign extRise = strobeSync & ~strobePrev & ~actIntUpdate;
	assign profChange = (profSync != profPrev);

	// ------------------------------------------------------------
	// Sync clock divider
	// ------------------------------------------------------------
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			divCnt <= 2'h0;
			syncClk <= 1'b0;
		end
		else
		begin
			divCnt <= divCnt + 2'h1;
			syncClk <= divCnt[1];
		end
	end

	// ------------------------------------------------------------
	// Transfer timing
	// ------------------------------------------------------------
	// Transfers are released only at one divider phase so latency is fixed to
	// the sync clock; an unaligned strobe waits up to one sync period.
	assign xferNow = (xferPending | extRise | profChange | intUpdate)
		& (divCnt == PUPC_SYNC_FIRE_PHASE);

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			xferPending <= 1'b0;
			transferPulse <= 1'b0;
		end
		else
		begin
			if (extRise | profChange | intUpdate)
				xferPending <= ~xferNow;
			else if (xferNow)
				xferPending <= 1'b0;
			transferPulse <= xferNow;
		end
	end

	// ------------------------------------------------------------
	// Serial buffer writes and power-down
	// ------------------------------------------------------------
	assign coreDown = pdDigital;
	// A write that clears the digital bit must get through or the core never wakes
	assign wrAllowed = ~coreDown | ~ctlWrPowerDown[PUPC_PD_DIGITAL];

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			bufRamEnable <= 1'b0;
			bufRamMode <= '0;
			bufNoDwell <= 1'b0;
			bufIntUpdate <= 1'b0;
			bufRateCtrl <= PUPC_RATE_CTRL_RST;
			bufRateWord <= PUPC_RATE_WORD_RST;
			pdBits <= '0;
			extPdFast <= 1'b0;
		end
		else if (ctlWrEn & wrAllowed)
		begin
			pdBits <= ctlWrPowerDown;
			extPdFast <= ctlWrExtPdFast;
			if (~coreDown)
			begin
				bufRamEnable <= ctlWrRamEnable;
				bufRamMode <= ctlWrRamMode;
				bufNoDwell <= ctlWrNoDwellHigh;
				bufIntUpdate <= ctlWrIntUpdate;
				bufRateCtrl <= ctlWrRateCtrl;
				bufRateWord <= ctlWrRateWord;
			end
		end
	end

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			pdDigital <= 1'b0;
			pdDac <= 1'b0;
			pdAux <= 1'b0;
			pdRefclk <= 1'b0;
			keepBiasPll <= 1'b0;
		end
		else
		begin
			pdDigital <= external_powerdown_pin | pdBits[PUPC_PD_DIGITAL];
			pdDac <= external_powerdown_pin | pdBits[PUPC_PD_DAC];
			pdAux <= external_powerdown_pin | pdBits[PUPC_PD_AUX];
			pdRefclk <= external_powerdown_pin | pdBits[PUPC_PD_REFCLK];
			keepBiasPll <= external_powerdown_pin & extPdFast;
		end
	end

	// ------------------------------------------------------------
	// Active registers
	// ------------------------------------------------------------
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			actRamEnable <= 1'b0;
			actRamMode <= '0;
			actNoDwell <= 1'b0;
			actIntUpdate <= 1'b0;
			actRateCtrl <= PUPC_RATE_CTRL_RST;
			actRateWord <= PUPC_RATE_WORD_RST;
			activeProfile <= '0;
		end
		else if (xferNow)
		begin
			actRamEnable <= bufRamEnable;
			actRamMode <= bufRamMode;
			actNoDwell <= bufNoDwell;
			actIntUpdate <= bufIntUpdate;
			actRateCtrl <= bufRateCtrl;
			actRateWord <= bufRateWord;
			activeProfile <= profSync;
		end
	end

	// Profile sets: written through the buffer path, one entry per generate pass
	for (genvar p = 0; p < PUPC_NPROF; p++)
	begin : g_prof
		logic [PUPC_ADDRW-1:0] bStart;
		logic [PUPC_ADDRW-1:0] bEnd;
		logic [PUPC_STEPW-1:0] bStep;
		always_ff @(posedge mclk or posedge sys_rst)
		begin
			if (sys_rst)
			begin
				bStart <= '0;
				bEnd <= '0;
				bStep <= '0;
			end
			else if (profWrEn & ~coreDown & (profWrIndex == PUPC_PROFW'(p)))
			begin
				bStart <= profWrStart;
				bEnd <= profWrEnd;
				bStep <= profWrStep;
			end
		end
		always_ff @(posedge mclk or posedge sys_rst)
		begin
			if (sys_rst)
			begin
				actStart[p] <= '0;
				actEnd[p] <= '0;
				actStep[p] <= '0;
			end
			else if (xferNow)
			begin
				actStart[p] <= bStart;
				actEnd[p] <= bEnd;
				actStep[p] <= bStep;
			end
		end
	end

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			singleToneFormat <= 1'b1;
			noDwellHighEff <= 1'b0;
		end
		else
		begin
			singleToneFormat <= ~actRamEnable;
			noDwellHighEff <= actNoDwell & ~recirc;
		end
	end

	// ------------------------------------------------------------
	// Automatic update timer
	// ------------------------------------------------------------
	assign rateStatic = (actRateWord <= PUPC_RATE_STATIC_MAX);
	assign intUpdate = actIntUpdate & ~rateStatic & (preCnt == 5'h00)
		& (rateCnt == actRateWord - 32'h1);

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			preCnt <= 5'h00;
			rateCnt <= '0;
		end
		else if (~actIntUpdate | rateStatic)
		begin
			preCnt <= 5'h00;
			rateCnt <= '0;
		end
		else
		begin
			// Quarter-rate clock divided by 1, 2, 4 or 8 ticks the range counter
			if (preCnt == (PUPC_PRESCALE_BASE << actRateCtrl) - 5'h01)
				preCnt <= 5'h00;
			else
				preCnt <= preCnt + 5'h01;
			if (preCnt == 5'h00)
				rateCnt <= intUpdate ? '0 : rateCnt + 32'h1;
		end
	end

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			pulseCnt <= 7'h00;
			updateStrobeOut <= 1'b0;
			updateStrobeOe <= 1'b0;
		end
		else
		begin
			updateStrobeOe <= actIntUpdate;
			if (intUpdate)
				pulseCnt <= PUPC_PULSE_BASE << actRateCtrl;
			else if (pulseCnt != 7'h00)
				pulseCnt <= pulseCnt - 7'h01;
			updateStrobeOut <= actIntUpdate & (rateStatic | intUpdate | (pulseCnt > 7'h01));
		end
	end

	// ------------------------------------------------------------
	// Continuous recirculate sequencer
	// ------------------------------------------------------------
	assign recirc = actRamEnable & (actRamMode == PUPC_MODE_RECIRC);
	assign selStart = actStart[activeProfile];
	assign selEnd = actEnd[activeProfile];
	assign selStep = actStep[activeProfile];
	// A zero step rate is treated as one cycle so the sequencer never stalls
	assign stepExpire = (stepCnt + 16'h1 >= selStep);

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			seqState <= PUPC_SEQ_IDLE;
			ramAddr <= '0;
			stepCnt <= '0;
		end
		else if (transferPulse)
		begin
			seqState <= recirc ? PUPC_SEQ_RUN : PUPC_SEQ_IDLE;
			ramAddr <= selStart;
			stepCnt <= '0;
		end
		else
		begin
			case (seqState)
				PUPC_SEQ_IDLE:
				begin
					stepCnt <= '0;
				end
				PUPC_SEQ_RUN:
				begin
					stepCnt <= stepExpire ? '0 : stepCnt + 16'h1;
					if (ramAddr == selEnd)
						seqState <= PUPC_SEQ_END;
					else if (stepExpire)
						ramAddr <= ramAddr + 10'h1;
				end
				PUPC_SEQ_END:
				begin
					stepCnt <= stepExpire ? '0 : stepCnt + 16'h1;
					if (stepExpire)
					begin
						ramAddr <= selStart;
						seqState <= PUPC_SEQ_RUN;
					end
				end
				default:
				begin
					seqState <= PUPC_SEQ_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			sweepCnt <= 2'h0;
			sweep_over_flag <= 1'b0;
		end
		else if (transferPulse)
		begin
			sweepCnt <= 2'h0;
			sweep_over_flag <= 1'b0;
		end
		else
		begin
			if (seqState == PUPC_SEQ_RUN && ramAddr == selEnd)
				sweepCnt <= PUPC_SWEEP_CYCLES;
			else if (sweepCnt != 2'h0)
				sweepCnt <= sweepCnt - 2'h1;
			sweep_over_flag <= (seqState == PUPC_SEQ_RUN && ramAddr == selEnd) | (sweepCnt > 2'h1);
		end
	end

endmodule // pupc_ctrl

//--- dv/pupc_partner.sv
// Model of the external controller on the profile pins and the update strobe
`timescale 1ns/10ps
module pupc_partner (
	// Timing reference
	input wire logic syncClk,
	// Pins driven by the controller
	output logic [2:0] profilePin,
	output logic strobeDrive
);
	initial
	begin
		profilePin = 3'h0;
		strobeDrive = 1'b0;
	end
	// Launch just after a sync clock edge so the latency stays constant
	task automatic strobe(input int hold);
		@(posedge syncClk);
		strobeDrive <= 1'b1;
		repeat (hold) @(posedge syncClk);
		strobeDrive <= 1'b0;
	endtask
	task automatic setProfile(input logic [2:0] p);
		@(posedge syncClk);
		profilePin <= p;
	endtask
endmodule // pupc_partner

//--- dv/pupc_ctrl_asserts.sv
// Port-level checks of the profile, update and power-down control block
`timescale 1ns/10ps
module pupc_ctrl_asserts (
	// Clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// Watched ports
	input wire logic syncClk,
	input wire logic ctlWrEn,
	input wire logic [pupc_pkg::PUPC_PDW-1:0] ctlWrPowerDown,
	input wire logic external_powerdown_pin,
	input wire logic [pupc_pkg::PUPC_PROFW-1:0] activeProfile,
	input wire logic singleToneFormat,
	input wire logic sweep_over_flag,
	input wire logic transferPulse,
	input wire logic updateStrobeOut,
	input wire logic updateStrobeOe,
	input wire logic pdDigital,
	input wire logic pdDac,
	input wire logic pdAux,
	input wire logic pdRefclk
);
	import pupc_pkg::*;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);
	sequence sweepTail;
		sweep_over_flag ##1 !sweep_over_flag;
	endsequence
	sequence pinLowWrite;
		!external_powerdown_pin [*4] ##0 (ctlWrEn && !pdDigital && !ctlWrPowerDown[0]) ##1 !external_powerdown_pin [*2];
	endsequence
	// A transfer may cut the pulse short, which the update rule wants
	sweep_two_a: assert property ($rose(sweep_over_flag) && !transferPulse |=> sweepTail)
		else $error("sweep pulse width");
	sync_period_a: assert property ($rose(syncClk) |=> syncClk ##1 !syncClk [*2] ##1 syncClk) else $error("sync period");
	xfer_clear_a: assert property (transferPulse |=> !sweep_over_flag) else $error("sweep not cleared");
	xfer_phase_a: assert property (transferPulse |=> !transferPulse [*3]) else $error("transfer spacing");
	// The format bit is registered once more, so it moves one cycle after the pulse
	act_hold_a: assert property ($changed({activeProfile, singleToneFormat})
		|-> transferPulse || $past(transferPulse)) else $error("active change without transfer");
	pin_down_a: assert property (external_powerdown_pin [*4]
		|-> pdDigital && pdDac && pdAux && pdRefclk) else $error("pin power-down");
	strobe_width_a: assert property (updateStrobeOe && $rose(updateStrobeOut) |=> updateStrobeOut [*8])
		else $error("strobe pulse short");
	pd_write_a: assert property (pinLowWrite |-> pdDac == $past(ctlWrPowerDown[1], 2)) else $error("dac power bit");
endmodule // pupc_ctrl_asserts

bind pupc_ctrl pupc_ctrl_asserts i_asserts (.mclk(mclk), .sys_rst(sys_rst), .syncClk(syncClk), .ctlWrEn(ctlWrEn),
	.ctlWrPowerDown(ctlWrPowerDown), .external_powerdown_pin(external_powerdown_pin), .activeProfile(activeProfile),
	.singleToneFormat(singleToneFormat), .sweep_over_flag(sweep_over_flag), .transferPulse(transferPulse),
	.updateStrobeOut(updateStrobeOut), .updateStrobeOe(updateStrobeOe), .pdDigital(pdDigital), .pdDac(pdDac),
	.pdAux(pdAux), .pdRefclk(pdRefclk));

//--- dv/pupc_ctrl_bench.sv
// Self-checking bench for the profile, update and power-down control block
`timescale 1ns/10ps
`define CHECK(g, e) begin comparisons++; if ((g) !== (e)) begin num_errors++; $display("ERROR %0t %h %h", $time, g, e); end end
module pupc_ctrl_bench;
	import pupc_pkg::*;
	logic mclk = 1'b0;
	logic sys_rst = 1'b1;
	logic updateStrobeIn, updateStrobeOut, updateStrobeOe, syncClk, strobeDrive, singleToneFormat, noDwellHighEff;
	logic sweep_over_flag, transferPulse, pdDigital, pdDac, pdAux, pdRefclk, keepBiasPll, autoRun;
	logic [2:0] profilePin, activeProfile, profWrIndex, ctlWrRamMode;
	logic ctlWrEn = 1'b0, ctlWrRamEnable, ctlWrNoDwellHigh, ctlWrIntUpdate, ctlWrExtPdFast, profWrEn = 1'b0;
	logic [1:0] ctlWrRateCtrl;
	logic [31:0] ctlWrRateWord;
	logic [3:0] ctlWrPowerDown, pdv;
	logic [9:0] profWrStart, profWrEnd, ramAddr, startA[8], endA[8];
	logic [15:0] profWrStep;
	logic external_powerdown_pin = 1'b0;
	logic [14:0] notes[$], note;
	int num_errors = 0, comparisons = 0, w, t;
	always #5 mclk = ~mclk;
	// The strobe pin is shared: the block wins while it drives
	assign updateStrobeIn = updateStrobeOe ? updateStrobeOut : strobeDrive;
	pupc_partner i_ctl (.syncClk(syncClk), .profilePin(profilePin), .strobeDrive(strobeDrive));
	pupc_ctrl i_dut (.mclk(mclk), .sys_rst(sys_rst), .profilePin(profilePin), .updateStrobeIn(updateStrobeIn),
		.updateStrobeOut(updateStrobeOut), .updateStrobeOe(updateStrobeOe), .syncClk(syncClk), .ctlWrEn(ctlWrEn),
		.ctlWrRamEnable(ctlWrRamEnable), .ctlWrRamMode(ctlWrRamMode), .ctlWrNoDwellHigh(ctlWrNoDwellHigh),
		.ctlWrIntUpdate(ctlWrIntUpdate), .ctlWrRateCtrl(ctlWrRateCtrl), .ctlWrRateWord(ctlWrRateWord),
		.ctlWrPowerDown(ctlWrPowerDown), .ctlWrExtPdFast(ctlWrExtPdFast), .profWrEn(profWrEn),
		.profWrIndex(profWrIndex), .profWrStart(profWrStart), .profWrEnd(profWrEnd), .profWrStep(profWrStep),
		.external_powerdown_pin(external_powerdown_pin), .activeProfile(activeProfile),
		.singleToneFormat(singleToneFormat), .noDwellHighEff(noDwellHighEff), .ramAddr(ramAddr),
		.sweep_over_flag(sweep_over_flag), .transferPulse(transferPulse), .pdDigital(pdDigital), .pdDac(pdDac),
		.pdAux(pdAux), .pdRefclk(pdRefclk), .keepBiasPll(keepBiasPll));
	task automatic stop_test();
		$display("comparisons %0d num_errors %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// No-dwell is always requested so recirculate must mask it
	task automatic ctlWrite(input logic ram, iu, input logic [1:0] a, input logic [31:0] b, input logic [3:0] pd, input logic f);
		@(posedge mclk);
		ctlWrEn <= 1'b1;
		ctlWrRamEnable <= ram;
		ctlWrRamMode <= PUPC_MODE_RECIRC;
		ctlWrNoDwellHigh <= 1'b1;
		ctlWrIntUpdate <= iu;
		ctlWrRateCtrl <= a;
		ctlWrRateWord <= b;
		ctlWrPowerDown <= pd;
		ctlWrExtPdFast <= f;
		@(posedge mclk);
		ctlWrEn <= 1'b0;
	endtask
	task automatic drain();
		repeat (40) if (notes.size() > 0) @(negedge mclk);
		`CHECK(notes.size(), 0)
	endtask
	// ------------------------------------------------------------
	// Transfer watcher: the sequencer loads one cycle after the pulse
	// ------------------------------------------------------------
	always @(negedge mclk)
	if (transferPulse)
	begin
		@(negedge mclk);
		if (notes.size() > 0)
		begin
			// Popped once: the check macro reads its expected value twice on a mismatch
			note = notes.pop_front();
			`CHECK({activeProfile, singleToneFormat, noDwellHighEff, ramAddr}, note)
		end
		else if (!autoRun)
			`CHECK(transferPulse, 1'bx)
	end
	initial
	begin
		#100000;
		num_errors++;
		stop_test();
	end
	initial
	begin
		autoRun = 1'b0;
		ctlWrite(0, 0, 0, 0, 0, 0);
		void'($urandom(3));
		repeat (5) @(posedge mclk);
		sys_rst <= 1'b0;
		for (int i = 0; i < 8; i++)
		begin
			startA[i] = 10'($urandom % 1000);
			endA[i] = startA[i] + 10'(1 + i % 3);
			@(posedge mclk);
			profWrEn <= 1'b1;
			profWrIndex <= 3'(i);
			profWrStart <= startA[i];
			profWrEnd <= endA[i];
			profWrStep <= 16'(2 + $urandom % 3);
			@(posedge mclk);
			profWrEn <= 1'b0;
		end
		ctlWrite(1, 0, 0, 32'hFFFF, 0, 0);
		notes.push_back({3'h0, 2'h0, startA[0]});
		i_ctl.strobe(1);
		drain();
		for (int p = 1; p < 8; p++)
		begin
			notes.push_back({3'(p), 2'h0, startA[p]});
			i_ctl.setProfile(3'(p));
			drain();
		end
		repeat (2)
		begin
			@(posedge sweep_over_flag);
			@(negedge mclk);
			`CHECK(ramAddr, endA[7])
			@(ramAddr);
			@(negedge mclk);
			`CHECK(ramAddr, startA[7])
			@(ramAddr);
			@(negedge mclk);
			`CHECK(ramAddr, startA[7] + 10'h1)
		end
		ctlWrite(0, 0, 0, 32'hFFFF, 0, 0);
		notes.push_back({3'h7, 2'h3, startA[7]});
		i_ctl.strobe(4);
		drain();
		pdv = 4'($urandom) & 4'hE;
		// Order matters: random bits with the digital bit clear, power the core down, refused write, waking write
		for (int k = 0; k < 4; k++)
		begin
			ctlWrite(0, 0, 0, 32'hFFFF, k == 0 ? pdv : (k == 1 ? 4'h1 : (k == 2 ? 4'hF : 4'h6)), 0);
			repeat (3) @(negedge mclk);
			`CHECK({pdRefclk, pdAux, pdDac, pdDigital}, k == 0 ? pdv : (k == 3 ? 4'h6 : 4'h1))
		end
		ctlWrite(0, 0, 0, 32'hFFFF, 0, 1);
		external_powerdown_pin <= 1'b1;
		repeat (6) @(negedge mclk);
		`CHECK({pdRefclk, pdAux, pdDac, pdDigital, keepBiasPll}, 5'h1F)
		ctlWrite(0, 0, 0, 32'hFFFF, 0, 0);
		repeat (3) @(negedge mclk);
		`CHECK({pdRefclk, pdAux, pdDac, pdDigital, keepBiasPll}, 5'h1E)
		external_powerdown_pin <= 1'b0;
		ctlWrite(1, 1, 0, 32'h8, 0, 0);
		notes.push_back({3'h7, 2'h0, startA[7]});
		i_ctl.strobe(1);
		drain();
		autoRun = 1'b1;
		`CHECK(updateStrobeOe, 1'b1)
		for (int a = 0; a < 4; a++)
		begin
			ctlWrite(1, 1, 2'(a), 32'h8, 0, 0);
			repeat (2) @(posedge updateStrobeOut);
			@(negedge mclk);
			for (w = 0; updateStrobeOut; w++) @(negedge mclk);
			for (t = w; !updateStrobeOut; t++) @(negedge mclk);
			`CHECK(w, 12 << a)
			`CHECK(t, 32 << a)
		end
		ctlWrite(1, 1, 0, 32'h3, 0, 0);
		// The new range word lands a cycle after the write, with the transfer still pending from the internal update just seen
		repeat (300) @(negedge mclk);
		repeat (8)
		begin
			repeat (40) @(negedge mclk);
			`CHECK(updateStrobeOut, 1'b1)
		end
		stop_test();
	end
endmodule // pupc_ctrl_bench
